// ==== src/reset_state_sequencer.sv ====
// Reset merging, halt timing, vector load and reset cause registers
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module reset_state_sequencer #(
  parameter int HALT_CYCLES_RC = rst_seq_pkg::HALT_CYCLES_RC,
  parameter int HALT_CYCLES_XTAL = rst_seq_pkg::HALT_CYCLES_XTAL
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic reset_pin_n,
  input wire logic poc_detect,
  input wire logic undervolt_reset_req,
  input wire logic dog_overflow,
  input wire logic osc_is_xtal,
  input wire logic [7:0] mem_data,
  output logic [15:0] vector_addr,
  output logic [15:0] pc,
  output logic cpu_run,
  output logic internal_reset,
  output logic dog_timer_reset,
  output logic init_load,
  output logic [rst_seq_pkg::NUM_INIT*16-1:0] init_image,
  output logic [7:0] undervolt_control,
  output logic [7:0] undervolt_level_select,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int HW = rst_seq_pkg::HALT_W;
  localparam int IW = rst_seq_pkg::IRQ_W;

  // ************************************************************
  // Reset sources
  // ************************************************************
  logic [2:0] src_sync;
  logic pin_req;
  logic poc_req;
  logic uv_req;
  logic any_req;
  logic clr_src;

  // Pin, power-on and undervolt levels come from outside the clock domain
  sync2 #(
    .W(3)
  ) u_src_sync (
    .clk(clk),
    .reset(reset),
    .d({undervolt_reset_req, poc_detect, ~reset_pin_n}),
    .q(src_sync)
  );

  // Merge the four requests into one reset
  assign pin_req = src_sync[0]; // RULE17
  assign poc_req = src_sync[1];
  assign uv_req = src_sync[2];
  assign any_req = pin_req || poc_req || uv_req || dog_overflow; // RULE18
  assign clr_src = pin_req || poc_req;

  // ************************************************************
  // Sequencer
  // ************************************************************
  rst_seq_pkg::seq_state_t state;
  rst_seq_pkg::seq_state_t next_state;
  logic halt_start;
  logic halt_done;
  logic halt_xtal;
  logic [HW-1:0] halt_limit;
  logic [15:0] next_vector_addr;

  // Reset, halt, fetch two vector bytes, run
  always_comb begin
    next_state = state;
    unique case (state)
      rst_seq_pkg::ST_RESET: next_state = rst_seq_pkg::ST_HALT;
      rst_seq_pkg::ST_HALT: if (halt_done) begin
        next_state = rst_seq_pkg::ST_FETCH_LO;
      end
      rst_seq_pkg::ST_FETCH_LO: next_state = rst_seq_pkg::ST_FETCH_HI;
      rst_seq_pkg::ST_FETCH_HI: next_state = rst_seq_pkg::ST_RUN;
      rst_seq_pkg::ST_RUN: next_state = rst_seq_pkg::ST_RUN;
      default: next_state = rst_seq_pkg::ST_RESET;
    endcase
    if (any_req) begin
      next_state = rst_seq_pkg::ST_RESET; // RULE18
    end
  end

  // Halt length depends on the oscillator kind
  assign halt_start = (state == rst_seq_pkg::ST_RESET) && !any_req;
  assign halt_limit = osc_is_xtal ? HW'(HALT_CYCLES_XTAL) : HW'(HALT_CYCLES_RC); // RULE1 RULE2
  assign next_vector_addr = (next_state == rst_seq_pkg::ST_FETCH_HI) ?
                            rst_seq_pkg::VEC_HI_ADDR : rst_seq_pkg::VEC_LO_ADDR; // RULE4

  halt_timer #(
    .W(HW)
  ) u_halt (
    .clk(clk),
    .reset(reset),
    .start(halt_start),
    .abort(any_req),
    .limit(halt_limit),
    .done(halt_done)
  );

  // State, oscillator kind and vector address
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= rst_seq_pkg::ST_RESET;
      halt_xtal <= 1'h0;
      vector_addr <= rst_seq_pkg::VEC_LO_ADDR;
    end else begin
      state <= next_state;
      vector_addr <= next_vector_addr;
      if (halt_start) begin
        halt_xtal <= osc_is_xtal;
      end
    end
  end

  // CPU held until the vector is in place
  assign cpu_run = (state == rst_seq_pkg::ST_RUN); // RULE1 RULE2
  assign internal_reset = (state == rst_seq_pkg::ST_RESET);

  // Program counter takes the vector word, low byte first
  always_ff @(posedge clk) begin
    if (reset) begin
      pc <= 16'h0000;
    end else if (state == rst_seq_pkg::ST_FETCH_LO) begin
      pc[7:0] <= mem_data; // RULE4
    end else if (state == rst_seq_pkg::ST_FETCH_HI) begin
      pc[15:8] <= mem_data; // RULE4
    end
  end

  // Peripheral values hold until reset completes, then load at once
  always_ff @(posedge clk) begin
    if (reset) begin
      init_load <= 1'h0;
      dog_timer_reset <= 1'h0;
    end else begin
      init_load <= (state == rst_seq_pkg::ST_FETCH_HI); // RULE5
      dog_timer_reset <= dog_overflow; // RULE3
    end
  end

  for (genvar i = 0; i < rst_seq_pkg::NUM_INIT; i++) begin : g_init
    always_ff @(posedge clk) begin
      if (reset || (state == rst_seq_pkg::ST_FETCH_HI)) begin
        init_image[i*16 +: 16] <= rst_seq_pkg::INIT_TABLE[i]; // RULE6 RULE7 RULE8
      end
    end
  end

  // ************************************************************
  // Register bus
  // ************************************************************
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_fire = (aw_held || aw_take) && (w_held || w_take) && !s_axi_bvalid;
  wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [7:0] wr_byte = w_held ? w_data[7:0] : s_axi_wdata[7:0];
  wire wr_lane = w_held ? w_lane0 : s_axi_wstrb[0];
  wire wr_uv_ctrl = wr_fire && wr_lane && (wr_addr == rst_seq_pkg::OFF_UV_CTRL);
  wire wr_uv_level = wr_fire && wr_lane && (wr_addr == rst_seq_pkg::OFF_UV_LEVEL);
  wire wr_mask = wr_fire && wr_lane && (wr_addr == rst_seq_pkg::OFF_IRQ_MASK);
  wire wr_hit = (wr_addr == rst_seq_pkg::OFF_UV_CTRL) ||
                (wr_addr == rst_seq_pkg::OFF_UV_LEVEL) ||
                (wr_addr == rst_seq_pkg::OFF_IRQ_MASK);

  // Address and data are taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  // Hold whichever half arrived first
  always_ff @(posedge clk) begin
    if (reset || wr_fire) begin
      aw_held <= 1'h0;
      w_held <= 1'h0;
    end else begin
      aw_held <= aw_held || aw_take;
      w_held <= w_held || w_take;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_lane0 <= 1'h0;
    end else begin
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
      end
    end
  end

  // Write response one cycle after both halves
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= rst_seq_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'h1;
      s_axi_bresp <= wr_hit ? rst_seq_pkg::RESP_OKAY : rst_seq_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'h0;
    end
  end

  // ************************************************************
  // Cause flags, undervolt settings, interrupts
  // ************************************************************
  logic cause_dog;
  logic cause_uv;
  logic [IW-1:0] irq_status;
  logic [IW-1:0] irq_mask;
  logic [IW-1:0] irq_event;
  logic [7:0] cause_flags;
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  wire rd_cause = rd_fire && (s_axi_araddr == rst_seq_pkg::OFF_CAUSE);
  wire rd_status = rd_fire && (s_axi_araddr == rst_seq_pkg::OFF_IRQ_STATUS);

  // Fixed layout, unused bits zero
  always_comb begin
    cause_flags = 8'h00;
    cause_flags[rst_seq_pkg::CAUSE_DOG_BIT] = cause_dog; // RULE16
    cause_flags[rst_seq_pkg::CAUSE_UV_BIT] = cause_uv; // RULE16
  end

  // Pin and power-on clear; dog and undervolt set; set beats read clear
  always_ff @(posedge clk) begin
    if (reset) begin
      cause_dog <= 1'h0;
      cause_uv <= 1'h0;
    end else begin
      cause_dog <= !clr_src && (dog_overflow || (cause_dog && !rd_cause)); // RULE13 RULE15
      cause_uv <= !clr_src && (uv_req || (cause_uv && !rd_cause)); // RULE13 RULE15
    end
  end

  // Undervolt settings survive only an undervolt reset
  always_ff @(posedge clk) begin
    if (reset || clr_src || dog_overflow) begin
      undervolt_control <= rst_seq_pkg::UV_RST; // RULE14
      undervolt_level_select <= rst_seq_pkg::UV_RST; // RULE14
    end else begin
      if (wr_uv_ctrl) begin
        undervolt_control <= wr_byte;
      end
      if (wr_uv_level) begin
        undervolt_level_select <= wr_byte;
      end
    end
  end

  // Sticky events, cleared by reading the status
  always_comb begin
    irq_event = '0;
    irq_event[rst_seq_pkg::IRQ_PIN] = pin_req;
    irq_event[rst_seq_pkg::IRQ_DOG] = dog_overflow;
    irq_event[rst_seq_pkg::IRQ_POC] = poc_req;
    irq_event[rst_seq_pkg::IRQ_UV] = uv_req;
    irq_event[rst_seq_pkg::IRQ_START] = (state == rst_seq_pkg::ST_FETCH_HI);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_status <= '0;
      irq_mask <= rst_seq_pkg::IRQ_MASK_RST;
    end else begin
      irq_status <= irq_event | (rd_status ? '0 : irq_status);
      if (wr_mask) begin
        irq_mask <= wr_byte[IW-1:0];
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Read data selection
  wire rd_hit = (s_axi_araddr == rst_seq_pkg::OFF_CAUSE) ||
                (s_axi_araddr == rst_seq_pkg::OFF_UV_CTRL) ||
                (s_axi_araddr == rst_seq_pkg::OFF_UV_LEVEL) ||
                (s_axi_araddr == rst_seq_pkg::OFF_IRQ_STATUS) ||
                (s_axi_araddr == rst_seq_pkg::OFF_IRQ_MASK) ||
                (s_axi_araddr == rst_seq_pkg::OFF_SEQ_STATE);
  wire [7:0] rd_byte =
    (s_axi_araddr == rst_seq_pkg::OFF_CAUSE) ? cause_flags :
    (s_axi_araddr == rst_seq_pkg::OFF_UV_CTRL) ? undervolt_control :
    (s_axi_araddr == rst_seq_pkg::OFF_UV_LEVEL) ? undervolt_level_select :
    (s_axi_araddr == rst_seq_pkg::OFF_IRQ_STATUS) ? {3'h0, irq_status} :
    (s_axi_araddr == rst_seq_pkg::OFF_IRQ_MASK) ? {3'h0, irq_mask} :
    (s_axi_araddr == rst_seq_pkg::OFF_SEQ_STATE) ? {4'h0, halt_xtal, state} : 8'h00;

  assign s_axi_arready = !s_axi_rvalid;

  // Read answer one cycle after the address
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= rst_seq_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'h1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_hit ? rst_seq_pkg::RESP_OKAY : rst_seq_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'h0;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  logic [HW-1:0] halt_len;

  // Cycles spent in the halt state
  always_ff @(posedge clk) begin
    if (reset || (state != rst_seq_pkg::ST_HALT)) begin
      halt_len <= '0;
    end else begin
      halt_len <= halt_len + HW'(1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_src_merge: assert property (any_req |=> internal_reset) // RULE18
    else $error("reset request did not reach internal reset");
  a_halt_rc_len: assert property ((halt_done && !halt_xtal && !any_req) // RULE1
    |-> halt_len == HW'(HALT_CYCLES_RC - 1))
    else $error("halt length wrong for internal clock");
  a_halt_xtal_len: assert property ((halt_done && halt_xtal && !any_req) // RULE2
    |-> halt_len == HW'(HALT_CYCLES_XTAL - 1))
    else $error("halt length wrong for crystal clock");
  a_halt_no_run: assert property ($fell(internal_reset) |-> !cpu_run [*8]) // RULE1
    else $error("cpu ran right after release");
  a_dog_timer_clear: assert property (dog_overflow |=> dog_timer_reset && internal_reset) // RULE3
    else $error("watchdog not returned to reset");
  a_vector_word: assert property ((state == rst_seq_pkg::ST_FETCH_HI && !any_req) // RULE4
    |=> pc == {$past(mem_data), $past(mem_data, 2)})
    else $error("program counter not loaded from vector");
  a_init_held: assert property ((state != rst_seq_pkg::ST_FETCH_HI) |=> $stable(init_image)) // RULE5
    else $error("peripheral values changed before completion");
  a_cause_dog_set: assert property ((dog_overflow && !clr_src) |=> // RULE13
    cause_flags == 8'h10 || cause_flags == 8'h11)
    else $error("dog cause flag not set");
  a_cause_clear: assert property (clr_src |=> cause_flags == 8'h00) // RULE13
    else $error("cause flags not cleared by pin or power-on reset");
  a_cause_read: assert property ((rd_cause && !any_req) |=> cause_flags == 8'h00) // RULE15
    else $error("cause flags survived a read");
  a_cause_layout: assert property ((cause_flags & 8'hEE) == 8'h00) // RULE16
    else $error("cause flags outside their bits");
  a_uv_kept: assert property ((uv_req && !clr_src && !dog_overflow) |=> // RULE14
    $stable(undervolt_control) && $stable(undervolt_level_select))
    else $error("undervolt settings lost on undervolt reset");

  c_boot: cover property (halt_done ##1 1 [*2] ##1 cpu_run);
  c_dog_reset: cover property (dog_overflow ##[1:20] cause_dog);
  c_uv_reset: cover property (uv_req ##1 cause_uv);
  c_cause_read: cover property (cause_dog && rd_cause);
endmodule : reset_state_sequencer
`default_nettype wire

// ==== src/rst_seq_pkg.sv ====
// Constants and types of the reset state sequencer
// Contract
// RULE1: Internal or external clock: CPU halts 277 us to 1.075 ms after release, 544 typical.
// RULE2: Crystal or ceramic clock: CPU halts 276 us to 1.074 ms after release.
// RULE3: A watchdog overflow reset also returns the watchdog timer to reset.
// RULE4: Program counter loads the vector word at 0000H and 0001H; stack pointer undefined.
// RULE5: During reset and stabilization only the PC is undefined; others hold.
// RULE6: Port latches, mode control, pull-ups cleared to 00H; port modes set FFH.
// RULE7: Wide timer count and capture/compare words 0000H; its control bytes 00H.
// RULE8: Byte timer compare registers and mode register cleared to 00H.
// RULE9: Watchdog mode register loads 67H, watchdog enable register loads 9AH.
// RULE10: ADC mode and channel registers cleared; conversion results left undefined.
// RULE11: Interrupt request and edge registers cleared; interrupt mask set to FFH.
// RULE12: Flash status, command, write buffer, compare registers cleared; others undefined.
// RULE13: Dog flag: clear on pin/POWER_ON_CLEAR, set on dog, hold on undervolt; undervolt flag mirrored.
// RULE14: Undervolt control and level select cleared, except on an undervolt reset.
// RULE15: Reading the reset cause register clears it to 00H.
// RULE16: Dog flag sits in bit 4, undervolt flag in bit 0; others zero.
// RULE17: The outside party holds the reset pin low at least 2 us.
// RULE18: All four reset sources merge into one reset; the firing source is recorded.
package rst_seq_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int HALT_MIN_RC_NS = 277000;
  localparam int HALT_TYP_RC_NS = 544000;
  localparam int HALT_MAX_RC_NS = 1075000;
  localparam int HALT_MIN_XTAL_NS = 276000;
  localparam int HALT_TYP_XTAL_NS = 544000;
  localparam int HALT_MAX_XTAL_NS = 1074000;
  localparam int PIN_LOW_MIN_NS = 2000;
  localparam int HALT_CYCLES_RC = (HALT_TYP_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALT_CYCLES_XTAL = (HALT_TYP_XTAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALT_W = 13;
  // ************************************************************
  // Vector and register map
  // ************************************************************
  localparam logic [15:0] VEC_LO_ADDR = 16'h0000; // RULE4
  localparam logic [15:0] VEC_HI_ADDR = 16'h0001; // RULE4
  localparam logic [7:0] OFF_CAUSE = 8'h00;
  localparam logic [7:0] OFF_UV_CTRL = 8'h04;
  localparam logic [7:0] OFF_UV_LEVEL = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_SEQ_STATE = 8'h14;
  localparam int CAUSE_DOG_BIT = 4;
  localparam int CAUSE_UV_BIT = 0;
  localparam logic [7:0] UV_RST = 8'h00;
  localparam int IRQ_W = 5;
  localparam int IRQ_PIN = 0;
  localparam int IRQ_DOG = 1;
  localparam int IRQ_POC = 2;
  localparam int IRQ_UV = 3;
  localparam int IRQ_START = 4;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ************************************************************
  // Peripheral values applied when reset completes
  // ************************************************************
  localparam int NUM_INIT = 26;
  localparam logic [15:0] INIT_TABLE [NUM_INIT] = '{
    16'h0000, // Port output latches RULE6
    16'h00FF, // Port mode registers, all inputs RULE6
    16'h0000, // port_mode_control RULE6
    16'h0000, // Pull-up option registers RULE6
    16'h0000, // wide_timer_count RULE7
    16'h0000, // wide_timer_capcmp_a RULE7
    16'h0000, // wide_timer_capcmp_b RULE7
    16'h0000, // Wide timer mode RULE7
    16'h0000, // Wide timer prescaler RULE7
    16'h0000, // Wide timer capture control RULE7
    16'h0000, // Wide timer output control RULE7
    16'h0000, // byte_timer_cmp_a RULE8
    16'h0000, // byte_timer_cmp_b RULE8
    16'h0000, // byte_timer_mode RULE8
    16'h0067, // dog_mode_reg RULE9
    16'h009A, // dog_enable_reg RULE9
    16'h0000, // adc_mode_reg RULE10
    16'h0000, // adc_channel_reg RULE10
    16'h0000, // irq_request_reg RULE11
    16'h00FF, // irq_mask_reg RULE11
    16'h0000, // ext_irq_edge_reg RULE11
    16'h0000, // flash_status_reg RULE12
    16'h0000, // flash_command_reg RULE12
    16'h0000, // flash_write_buffer RULE12
    16'h0000, // Flash pointer high compare RULE12
    16'h0000  // Flash pointer low compare RULE12
  };
  // ************************************************************
  // Sequencer states
  // ************************************************************
  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_HALT = 3'h1,
    ST_FETCH_LO = 3'h3,
    ST_FETCH_HI = 3'h2,
    ST_RUN = 3'h6
  } seq_state_t;
endpackage : rst_seq_pkg

// ==== src/sync2.sv ====
// Two flip-flop synchroniser for asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] stage;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      stage <= '0;
      q <= '0;
    end else begin
      stage <= d;
      q <= stage;
    end
  end
endmodule : sync2
`default_nettype wire

// ==== src/halt_timer.sv ====
// Down counter that times the CPU halt after reset release
`timescale 1ns/10ps
`default_nettype none
module halt_timer #(
  parameter int W = 13
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic abort,
  input wire logic [W-1:0] limit,
  output logic done
);
  logic [W-1:0] count;
  logic busy;

  // Last counted cycle
  assign done = busy && (count == '0);

  // Load limit minus one, run down to zero
  always_ff @(posedge clk) begin
    if (reset || abort) begin
      busy <= 1'h0;
      count <= '0;
    end else if (start) begin
      busy <= 1'h1;
      count <= limit - W'(1);
    end else if (done) begin
      busy <= 1'h0;
    end else if (busy) begin
      count <= count - W'(1);
    end
  end
endmodule : halt_timer
`default_nettype wire

// ==== sim/reset_sources_model.sv ====
// Reset sources and vector memory facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module reset_sources_model #(
  parameter logic [15:0] VECTOR = 16'hA55C
) (
  input wire logic clk,
  input wire logic [2:0] fire,
  input wire logic [15:0] vector_addr,
  output logic [7:0] mem_data,
  output logic reset_pin_n,
  output logic poc_detect,
  output logic undervolt_reset_req,
  output logic dog_overflow
);
  int left = 0;
  logic [1:0] src = 2'h0;
  // Vector word at bytes 0 and 1, changing junk elsewhere
  assign mem_data = (vector_addr == 16'h0000) ? VECTOR[7:0] :
    (vector_addr == 16'h0001) ? VECTOR[15:8] : ~vector_addr[7:0];
  // Hold a request: 20 cycles (2 us), watchdog one cycle
  always @(posedge clk) begin
    if (fire[2]) begin
      src <= fire[1:0];
      left <= (fire[1:0] == 2'h1) ? 1 : 20;
    end else if (left > 0) begin
      left <= left - 1;
    end
  end
  // Source codes: 0 pin, 1 watchdog, 2 power-on, 3 undervolt
  assign reset_pin_n = !(left > 0 && src == 2'h0);
  assign dog_overflow = left > 0 && src == 2'h1;
  assign poc_detect = left > 0 && src == 2'h2;
  assign undervolt_reset_req = left > 0 && src == 2'h3;
endmodule : reset_sources_model
`default_nettype wire

// ==== sim/reset_state_sequencer_bench.sv ====
// Self-checking bench of the reset state sequencer
`timescale 1ns/10ps
`default_nettype none
module reset_state_sequencer_bench;
  localparam logic [15:0] VEC = 16'hA55C;
  localparam int HRC = 20;
  localparam int HXT = 24;
  logic clk, reset, osc_is_xtal, s_axi_awvalid, s_axi_wvalid, s_axi_bready, x;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, reset_pin_n, poc_detect, undervolt_reset_req;
  logic dog_overflow, cpu_run, internal_reset, dog_timer_reset, init_load, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, mem_data, a, b, cause;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, src;
  logic [15:0] vector_addr, pc;
  logic [2:0] fire;
  logic [rst_seq_pkg::NUM_INIT*16-1:0] init_image;
  int seed, n, cycles, miscompares, comparisons;
  reset_sources_model #(.VECTOR(VEC)) partner (.clk, .fire, .vector_addr, .mem_data,
    .reset_pin_n, .poc_detect, .undervolt_reset_req, .dog_overflow);
  reset_state_sequencer #(.HALT_CYCLES_RC(HRC), .HALT_CYCLES_XTAL(HXT)) DUT (
    .clk, .reset, .reset_pin_n, .poc_detect, .undervolt_reset_req, .dog_overflow,
    .osc_is_xtal, .mem_data, .vector_addr, .pc, .cpu_run, .internal_reset,
    .dog_timer_reset, .init_load, .init_image, .undervolt_control(),
    .undervolt_level_select(), .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [15:0] exp_init(input int i);
    case (i)
      1, 19: return 16'h00FF;
      14: return 16'h0067;
      15: return 16'h009A;
      default: return 16'h0000;
    endcase
  endfunction : exp_init
  task chk(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk
  task give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // Bus write: handshake seen at negedge holds until the rising edge
  task wr(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] rs);
    logic ta, tw, tb;
    @(posedge clk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid & s_axi_bready;
      rs = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    logic ta, tb;
    @(posedge clk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk);
      ta = s_axi_arvalid & s_axi_arready;
      tb = s_axi_rvalid & s_axi_rready;
      dt = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : rd
  // Follow one reset through halt and vector fetch
  task boot;
    n = 0;
    while (internal_reset !== 1'b1) @(negedge clk);
    while (internal_reset !== 1'b0) @(negedge clk);
    while (cpu_run !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    chk(n, (x ? HXT : HRC) + 2);
    chk(pc, VEC);
    chk(init_load, 1'b1);
    for (int i = 0; i < rst_seq_pkg::NUM_INIT; i++) begin
      chk(init_image[16*i+:16], exp_init(i));
    end
  endtask : boot
  // ************************************************************
  // Clock, timeout and sequence
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      give_verdict;
    end
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    seed = 11727;
    reset = 1'b1;
    osc_is_xtal = 1'b0;
    x = 1'b0;
    fire = 3'h0;
    cause = 8'h00;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    boot;
    // Interrupt: masked, unmasked, cleared by status read
    chk(irq, 1'b0);
    wr(8'h10, 32'h10, r);
    @(negedge clk);
    chk(irq, 1'b1);
    rd(8'h0C, d, r);
    chk(d, 32'h10);
    @(negedge clk);
    chk(irq, 1'b0);
    wr(8'h00, 32'hFF, r);
    chk(r, rst_seq_pkg::RESP_SLVERR);
    rd(8'h40, d, r);
    chk({d, r}, {32'h0, rst_seq_pkg::RESP_SLVERR});
    // Write with lane 0 off is accepted and ignored
    s_axi_wstrb <= 4'hE;
    wr(8'h10, 32'h0, r);
    chk(r, rst_seq_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(8'h10, d, r);
    chk(d, 32'h10);
    // Every source first, then random ones
    for (int k = 0; k < 10; k++) begin
      src = (k < 4) ? k[1:0] : 2'($random(seed));
      x = 1'($random(seed));
      a = 8'($random(seed));
      b = 8'($random(seed));
      wr(8'h04, {24'h0, a}, r);
      wr(8'h08, {24'h0, b}, r);
      osc_is_xtal <= x;
      fire <= {1'b1, src};
      @(posedge clk);
      fire <= 3'h0;
      if (src == 2'h1) begin
        @(negedge clk);
        @(negedge clk);
        chk(dog_timer_reset, 1'b1);
      end
      if (!src[0]) cause = 8'h00;
      else cause = cause | (src[1] ? 8'h01 : 8'h10);
      boot;
      rd(8'h14, d, r);
      chk(d, {28'h0, x, rst_seq_pkg::ST_RUN});
      rd(8'h04, d, r);
      chk(d, (src == 2'h3) ? {24'h0, a} : 32'h0);
      rd(8'h08, d, r);
      chk(d, (src == 2'h3) ? {24'h0, b} : 32'h0);
      if (k == 9 || ($random(seed) & 1)) begin
        rd(8'h00, d, r);
        chk(d, {24'h0, cause});
        rd(8'h00, d, r);
        chk(d, 32'h0);
        cause = 8'h00;
      end
    end
    give_verdict;
  end
endmodule : reset_state_sequencer_bench
`default_nettype wire
